// [rtl/csia_pkg.sv]
// Constants, register map and types for the core stack and pointer block.
// Assumes one 250 MHz clock, active-low async reset and an Avalon-MM master.
package csia_pkg;
   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int STK_DEPTH = 16;
   localparam int STK_IDX_W = 4;
   localparam int PC_W = 15;
   localparam int PTR_W = 16;
   localparam int DATA_W = 8;
   localparam int DADDR_W = 13;
   localparam int BSR_W = 6;
   localparam int OPC_W = 6;
   localparam logic [OPC_W-1:0] NUM_INSTR = 6'h30;
   // ----------------------------------------------------------------
   // Pointer space
   // ----------------------------------------------------------------
   localparam int PROG_PTR_BIT = 15;
   localparam logic [3:0] LIN_REGION = 4'h2;
   localparam logic [11:0] LIN_BANK_BYTES = 12'h050;
   localparam logic [6:0] GPR_START = 7'h20;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_POWER_CONTROL_STATUS_REG = 8'h04;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADR_PTR0 = 8'h10;
   localparam logic [7:0] ADR_PTR1 = 8'h14;
   localparam logic [7:0] ADR_DEPTH = 8'h18;
   localparam logic [7:0] ADR_WREG = 8'h1C;
   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_FRST_BIT = 0;
   localparam int POWER_CONTROL_STATUS_REG_OVF_BIT = 0;
   localparam int POWER_CONTROL_STATUS_REG_UNF_BIT = 1;
   localparam int EVT_W = 3;
   localparam int EVT_OVF_BIT = 0;
   localparam int EVT_UNF_BIT = 1;
   localparam int EVT_ILL_BIT = 2;
   localparam int STAT_C_BIT = 0;
   localparam int STAT_Z_BIT = 2;
   localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
   localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
   localparam logic [BSR_W-1:0] BSR_RST = 6'h00;
   localparam logic [EVT_W-1:0] EVT_RST = 3'h0;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      AM_DIRECT = 2'h0,
      AM_IND0 = 2'h1,
      AM_IND1 = 2'h2,
      AM_REL = 2'h3
   } csia_amode_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXTRA = 2'b10
   } csia_state_t;
endpackage

// [rtl/csia_stack.sv]
// Sixteen-entry return-address stack held in flip-flops.
// Assumes the caller never pushes and pops in one cycle; push then wins.
`timescale 1ns/100ps
`default_nettype none
module csia_stack
   import csia_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_push,
   input wire logic i_pop,
   input wire logic [PC_W-1:0] i_push_pc,
   output logic [PC_W-1:0] o_top_pc,
   output logic [STK_IDX_W:0] o_depth,
   output logic o_ovf_evt,
   output logic o_unf_evt
);
   logic [PC_W-1:0] mem_r [STK_DEPTH];
   logic [STK_IDX_W:0] sp_r;
   logic [PC_W-1:0] top_r;
   logic full_w;
   logic empty_w;
   logic do_push_w;
   logic do_pop_w;
   logic [STK_IDX_W-1:0] top_idx_w;

   assign full_w = (sp_r == (STK_IDX_W+1)'(STK_DEPTH));
   assign empty_w = (sp_r == '0);
   assign do_push_w = i_ce & i_push & ~full_w;
   assign do_pop_w = i_ce & i_pop & ~i_push & ~empty_w;
   assign o_ovf_evt = i_ce & i_push & full_w;
   assign o_unf_evt = i_ce & i_pop & ~i_push & empty_w;
   assign top_idx_w = STK_IDX_W'(sp_r - 1'b1);
   assign o_top_pc = top_r;
   assign o_depth = sp_r;

   // ----------------------------------------------------------------
   // Entry storage
   // ----------------------------------------------------------------
   for (genvar gi = 0; gi < STK_DEPTH; gi++) begin : g_ent
      always_ff @(posedge i_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            mem_r[gi] <= '0;
         end else if (do_push_w && sp_r[STK_IDX_W-1:0] == STK_IDX_W'(gi)) begin
            mem_r[gi] <= i_push_pc;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pointer and popped value
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sp_r <= '0;
         top_r <= '0;
      end else if (do_push_w) begin
         sp_r <= sp_r + 1'b1;
      end else if (do_pop_w) begin
         sp_r <= sp_r - 1'b1;
         top_r <= mem_r[top_idx_w];
      end else if (i_ce && i_pop) begin
         top_r <= '0;
      end
   end
endmodule
`default_nettype wire

// [rtl/csia_core.sv]
// Core support: return stack, fault flags, pointers, shadow context,
// operand address generation and an 8-bit working-register unit.
// Assumes a same-clock core drives the request inputs and memories
// sit outside; software uses Avalon-MM with waitrequest.
`timescale 1ns/100ps
`default_nettype none
module csia_core
   import csia_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_irq,
   input wire logic i_call,
   input wire logic i_ret,
   input wire logic [PC_W-1:0] i_ret_pc,
   output logic [PC_W-1:0] o_ret_pc,
   output logic o_soft_rst,
   input wire logic i_int_entry,
   input wire logic i_int_return,
   input wire logic i_bsr_we,
   input wire logic [BSR_W-1:0] i_bsr_d,
   output logic [BSR_W-1:0] o_bsr,
   input wire logic i_op_valid,
   input wire logic [1:0] i_op_mode,
   input wire logic [6:0] i_op_f,
   input wire logic [8:0] i_op_rel,
   input wire logic [PC_W-1:0] i_pc,
   output logic o_op_ready,
   output logic o_op_done,
   output logic o_op_prog,
   output logic [PC_W-1:0] o_op_addr,
   input wire logic i_alu_valid,
   input wire logic [OPC_W-1:0] i_alu_opcode,
   input wire logic [DATA_W-1:0] i_alu_operand,
   output logic [DATA_W-1:0] o_alu_result,
   output logic [DATA_W-1:0] o_wreg,
   output logic [DATA_W-1:0] o_status
);
   // ----------------------------------------------------------------
   // Pointer decoding
   // ----------------------------------------------------------------
   function automatic logic [PTR_W-1:0] ptr_map(input logic [PTR_W-1:0] p);
      logic [11:0] off;
      logic [11:0] bank;
      logic [11:0] rem;
      off = p[11:0];
      bank = off / LIN_BANK_BYTES;
      rem = off % LIN_BANK_BYTES;
      if (p[PROG_PTR_BIT]) begin
         ptr_map = p;
      end else if (p[15:12] == LIN_REGION) begin
         ptr_map = {3'h0, bank[5:0], 7'(GPR_START + rem[6:0])};
      end else begin
         ptr_map = {3'h0, p[DADDR_W-1:0]};
      end
   endfunction

   logic ctrl_frst_r;
   logic [1:0] power_control_status_reg_r;
   logic [EVT_W-1:0] irq_stat_r;
   logic [EVT_W-1:0] irq_mask_r;
   logic [PTR_W-1:0] ptr0_r;
   logic [PTR_W-1:0] ptr1_r;
   logic [DATA_W-1:0] w_r;
   logic [DATA_W-1:0] stat_r;
   logic [BSR_W-1:0] bsr_r;
   logic [DATA_W-1:0] sh_w_r;
   logic [DATA_W-1:0] sh_stat_r;
   logic [BSR_W-1:0] sh_bsr_r;
   logic [PTR_W-1:0] sh_ptr0_r;
   logic [PTR_W-1:0] sh_ptr1_r;
   logic ack_r;
   logic [31:0] rdata_r;
   logic soft_rst_r;
   csia_state_t state_r;
   csia_state_t state_nxt;
   logic done_r;
   logic prog_r;
   logic [PC_W-1:0] addr_r;
   logic [DATA_W-1:0] alu_r;

   // ----------------------------------------------------------------
   // Return stack
   // ----------------------------------------------------------------
   logic ovf_w;
   logic unf_w;
   logic [STK_IDX_W:0] depth_w;

   csia_stack u_stack (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .i_push(i_call),
      .i_pop(i_ret),
      .i_push_pc(i_ret_pc),
      .o_top_pc(o_ret_pc),
      .o_depth(depth_w),
      .o_ovf_evt(ovf_w),
      .o_unf_evt(unf_w)
   );

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic req_w;
   logic acc_w;
   logic wr_w;
   logic rd_w;
   logic [15:0] wmask_w;
   logic [31:0] rsel_w;
   logic ill_w;
   logic [EVT_W-1:0] evt_w;
   logic fault_w;
   logic hit_ptr0_w;
   logic hit_ptr1_w;

   assign req_w = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req_w & ~ack_r;
   assign acc_w = i_ce & req_w & ack_r;
   assign wr_w = acc_w & i_avs_write;
   assign rd_w = acc_w & i_avs_read;
   assign wmask_w = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
   assign hit_ptr0_w = wr_w & (i_avs_address == ADR_PTR0);
   assign hit_ptr1_w = wr_w & (i_avs_address == ADR_PTR1);
   assign rsel_w = (i_avs_address == ADR_CTRL) ? {31'h0, ctrl_frst_r} :
                   (i_avs_address == ADR_POWER_CONTROL_STATUS_REG) ? {30'h0, power_control_status_reg_r} :
                   (i_avs_address == ADR_IRQ_STAT) ? {29'h0, irq_stat_r} :
                   (i_avs_address == ADR_IRQ_MASK) ? {29'h0, irq_mask_r} :
                   (i_avs_address == ADR_PTR0) ? {16'h0, ptr0_r} :
                   (i_avs_address == ADR_PTR1) ? {16'h0, ptr1_r} :
                   (i_avs_address == ADR_DEPTH) ? {27'h0, depth_w} :
                   (i_avs_address == ADR_WREG) ? {24'h0, w_r} : 32'h0000_0000;
   assign o_avs_readdata = rdata_r;

   assign ill_w = i_ce & i_alu_valid & (i_alu_opcode >= NUM_INSTR);
   assign evt_w = {ill_w, unf_w, ovf_w};
   assign fault_w = ovf_w | unf_w;
   assign o_irq = |(irq_stat_r & irq_mask_r);

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ack_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else if (i_ce) begin
         ack_r <= req_w & ~ack_r;
         if (i_avs_read && !ack_r) begin
            rdata_r <= rsel_w;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control, fault flags and interrupt status
   // ----------------------------------------------------------------
   logic [1:0] power_control_status_reg_clr_w;
   logic [EVT_W-1:0] irq_clr_w;

   assign power_control_status_reg_clr_w = (wr_w && i_avs_address == ADR_POWER_CONTROL_STATUS_REG && i_avs_byteenable[0]) ?
                       i_avs_writedata[1:0] : 2'h0;
   assign irq_clr_w = (rd_w && i_avs_address == ADR_IRQ_STAT) ? rdata_r[EVT_W-1:0] : EVT_RST;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_frst_r <= 1'b0;
         power_control_status_reg_r <= 2'h0;
         irq_stat_r <= EVT_RST;
         irq_mask_r <= EVT_RST;
         soft_rst_r <= 1'b0;
      end else if (i_ce) begin
         if (wr_w && i_avs_address == ADR_CTRL && i_avs_byteenable[0]) begin
            ctrl_frst_r <= i_avs_writedata[CTRL_FRST_BIT];
         end
         if (wr_w && i_avs_address == ADR_IRQ_MASK && i_avs_byteenable[0]) begin
            irq_mask_r <= i_avs_writedata[EVT_W-1:0];
         end
         power_control_status_reg_r <= (power_control_status_reg_r & ~power_control_status_reg_clr_w) | {unf_w, ovf_w};
         irq_stat_r <= (irq_stat_r & ~irq_clr_w) | evt_w;
         soft_rst_r <= fault_w & ctrl_frst_r;
      end
   end
   assign o_soft_rst = soft_rst_r;

   // ----------------------------------------------------------------
   // Pointers, working register, bank and shadow context
   // ----------------------------------------------------------------
   logic [8:0] alu_w;
   logic alu_wr_w;

   always_comb begin
      alu_w = 9'h000;
      unique case (i_alu_opcode[2:0])
         3'h0: alu_w = {1'b0, i_alu_operand};
         3'h1: alu_w = {1'b0, w_r} + {1'b0, i_alu_operand};
         3'h2: alu_w = {1'b0, w_r} - {1'b0, i_alu_operand};
         3'h3: alu_w = {1'b0, w_r & i_alu_operand};
         3'h4: alu_w = {1'b0, w_r | i_alu_operand};
         3'h5: alu_w = {1'b0, w_r ^ i_alu_operand};
         3'h6: alu_w = {1'b0, i_alu_operand} + 9'h001;
         3'h7: alu_w = 9'h000;
      endcase
   end
   assign alu_wr_w = i_alu_valid & (i_alu_opcode < NUM_INSTR);

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sh_w_r <= BYTE_RST;
         sh_stat_r <= BYTE_RST;
         sh_bsr_r <= BSR_RST;
         sh_ptr0_r <= PTR_RST;
         sh_ptr1_r <= PTR_RST;
      end else if (i_ce && i_int_entry) begin
         sh_w_r <= w_r;
         sh_stat_r <= stat_r;
         sh_bsr_r <= bsr_r;
         sh_ptr0_r <= ptr0_r;
         sh_ptr1_r <= ptr1_r;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ptr0_r <= PTR_RST;
         ptr1_r <= PTR_RST;
         w_r <= BYTE_RST;
         stat_r <= BYTE_RST;
         bsr_r <= BSR_RST;
         alu_r <= BYTE_RST;
      end else if (i_ce && i_int_return) begin
         ptr0_r <= sh_ptr0_r;
         ptr1_r <= sh_ptr1_r;
         w_r <= sh_w_r;
         stat_r <= sh_stat_r;
         bsr_r <= sh_bsr_r;
      end else if (i_ce) begin
         if (hit_ptr0_w) begin
            ptr0_r <= (ptr0_r & ~wmask_w) | (i_avs_writedata[15:0] & wmask_w);
         end
         if (hit_ptr1_w) begin
            ptr1_r <= (ptr1_r & ~wmask_w) | (i_avs_writedata[15:0] & wmask_w);
         end
         if (i_bsr_we) begin
            bsr_r <= i_bsr_d;
         end
         if (alu_wr_w) begin
            w_r <= alu_w[DATA_W-1:0];
            alu_r <= alu_w[DATA_W-1:0];
            stat_r[STAT_C_BIT] <= alu_w[DATA_W];
            stat_r[STAT_Z_BIT] <= (alu_w[DATA_W-1:0] == BYTE_RST);
         end
      end
   end
   assign o_wreg = w_r;
   assign o_status = stat_r;
   assign o_bsr = bsr_r;
   assign o_alu_result = alu_r;

   // ----------------------------------------------------------------
   // Operand address generation
   // ----------------------------------------------------------------
   logic [PTR_W-1:0] map0_w;
   logic [PTR_W-1:0] map1_w;
   logic [PTR_W-1:0] map_sel_w;
   logic ind_w;
   logic [PC_W-1:0] direct_w;
   logic [PC_W-1:0] rel_w;
   logic take_w;

   assign map0_w = ptr_map(ptr0_r);
   assign map1_w = ptr_map(ptr1_r);
   assign ind_w = (i_op_mode == AM_IND0) | (i_op_mode == AM_IND1);
   assign map_sel_w = (i_op_mode == AM_IND1) ? map1_w : map0_w;
   assign direct_w = {2'h0, bsr_r, i_op_f};
   assign rel_w = PC_W'(i_pc + 1'b1 + {{6{i_op_rel[8]}}, i_op_rel});
   assign o_op_ready = (state_r == ST_IDLE);
   assign take_w = i_ce & i_op_valid & o_op_ready;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (take_w && ind_w && map_sel_w[PROG_PTR_BIT]) begin
               state_nxt = ST_EXTRA;
            end
         end
         ST_EXTRA: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_r <= ST_IDLE;
         done_r <= 1'b0;
         prog_r <= 1'b0;
         addr_r <= '0;
      end else if (i_ce) begin
         state_r <= state_nxt;
         done_r <= (take_w && state_nxt == ST_IDLE) || (state_r == ST_EXTRA);
         if (take_w) begin
            unique case (i_op_mode)
               AM_DIRECT: begin
                  prog_r <= 1'b0;
                  addr_r <= direct_w;
               end
               AM_IND0, AM_IND1: begin
                  prog_r <= map_sel_w[PROG_PTR_BIT];
                  addr_r <= map_sel_w[PC_W-1:0];
               end
               AM_REL: begin
                  prog_r <= 1'b1;
                  addr_r <= rel_w;
               end
            endcase
         end
      end
   end
   assign o_op_done = done_r;
   assign o_op_prog = prog_r;
   assign o_op_addr = addr_r;
endmodule
`default_nettype wire

// [dv/csia_mem_model.sv]
// Program and data memory seen through the operand address outputs.
// Assumes the core's registered done, prog and address outputs.
`timescale 1ns/100ps
`default_nettype none
module csia_mem_model (
   input wire logic i_clk,
   input wire logic i_done,
   input wire logic i_prog,
   input wire logic [14:0] i_addr,
   output logic [7:0] o_q
);
   logic [7:0] last_r;
   // Program reads invert bit 7 of the data answer; released data shows the inverse
   assign o_q = i_done ? (i_addr[7:0] ^ {i_prog, 7'h00}) : ~last_r;
   always_ff @(posedge i_clk) begin
      last_r <= o_q;
   end
endmodule
`default_nettype wire

// [dv/csia_core_properties.sv]
// Checker for the stack, operand and working-register outputs.
// Assumes it is bound into csia_core and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module csia_core_chk
   import csia_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_call,
   input wire logic i_ret,
   input wire logic [PC_W-1:0] i_ret_pc,
   input wire logic [PC_W-1:0] o_ret_pc,
   input wire logic o_soft_rst,
   input wire logic [BSR_W-1:0] o_bsr,
   input wire logic i_op_valid,
   input wire logic [1:0] i_op_mode,
   input wire logic [6:0] i_op_f,
   input wire logic [8:0] i_op_rel,
   input wire logic [PC_W-1:0] i_pc,
   input wire logic o_op_ready,
   input wire logic o_op_done,
   input wire logic o_op_prog,
   input wire logic [PC_W-1:0] o_op_addr,
   input wire logic i_alu_valid,
   input wire logic [OPC_W-1:0] i_alu_opcode,
   input wire logic [DATA_W-1:0] i_alu_operand,
   input wire logic [DATA_W-1:0] o_wreg,
   input wire logic [DATA_W-1:0] o_status
);
   // ------
   // Helper logic
   // ------
   logic [4:0] dep_r;
   wire logic push = i_ce & i_call;
   wire logic pop = i_ce & i_ret & ~i_call;
   wire logic full = dep_r == 5'h10;
   wire logic empty = dep_r == 5'h00;
   wire logic fault = (push & full) | (pop & empty);
   wire logic take = i_ce & i_op_valid & o_op_ready;
   wire logic alu = i_ce & i_alu_valid;
   wire logic [PC_W-1:0] rel_addr = i_pc + 15'h0001 + {{6{i_op_rel[8]}}, i_op_rel};
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) dep_r <= 5'h00;
      else if (push & ~full) dep_r <= dep_r + 5'h01;
      else if (pop & ~empty) dep_r <= dep_r - 5'h01;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // ------
   // Properties
   // ------
   a_rst_cause: assert property (o_soft_rst |-> $past(fault))
      else $error("soft reset without stack fault");
   a_pop_empty: assert property (pop && empty |=> o_ret_pc == 15'h0000)
      else $error("empty pop gave nonzero pc");
   a_push_pop_lifo: assert property (push && !full ##1 pop |=> o_ret_pc == $past(i_ret_pc, 2))
      else $error("pop did not return last push");
   a_op_direct: assert property (take && i_op_mode == AM_DIRECT |=>
      o_op_done && !o_op_prog && o_op_addr == {2'b00, $past(o_bsr), $past(i_op_f)})
      else $error("direct address wrong");
   a_op_rel: assert property (take && i_op_mode == AM_REL |=> o_op_done && o_op_addr == $past(rel_addr))
      else $error("relative address wrong");
   a_ind_latency: assert property (take && i_op_mode inside {AM_IND0, AM_IND1} |=>
      (o_op_done && !o_op_prog) or (!o_op_done && !o_op_ready ##1 o_op_done && o_op_prog))
      else $error("indirect latency wrong");
   a_busy_prog: assert property (!o_op_ready |=> o_op_done && o_op_prog)
      else $error("busy cycle not followed by program fetch");
   a_alu_clear: assert property (alu && i_alu_opcode == 6'h07 |=> o_wreg == 8'h00 && o_status[STAT_Z_BIT])
      else $error("clear wrong");
   a_alu_add: assert property (alu && i_alu_opcode == 6'h01 |=>
      {o_status[STAT_C_BIT], o_wreg} == {1'b0, $past(o_wreg)} + {1'b0, $past(i_alu_operand)})
      else $error("add wrong");
   a_ill_noop: assert property (alu && i_alu_opcode >= NUM_INSTR |=> $stable(o_wreg))
      else $error("illegal opcode changed w");
   c_soft_rst: cover property (o_soft_rst);
   c_prog_wait: cover property (!o_op_ready);
   c_overflow: cover property (push && full);
   c_underflow: cover property (pop && empty);
endmodule
bind csia_core csia_core_chk i_csia_core_chk (.*);
`default_nettype wire

// [dv/cpu_stack_indirect_addressing_test.sv]
// Self-checking bench for csia_core over its Avalon-MM and core ports.
// Assumes the checker bind and the memory model are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module cpu_stack_indirect_addressing_test;
   import csia_pkg::*;
   logic i_clk = 1'b0, i_rst_b = 1'b0, i_ce = 1'b1;
   logic [7:0] i_avs_address = 8'h00;
   logic i_avs_read = 1'b0, i_avs_write = 1'b0, o_avs_waitrequest, o_irq;
   logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q;
   logic [3:0] i_avs_byteenable = 4'hF;
   logic i_call = 1'b0, i_ret = 1'b0, i_int_entry = 1'b0, i_int_return = 1'b0;
   logic i_bsr_we = 1'b0, i_op_valid = 1'b0, i_alu_valid = 1'b0;
   logic o_soft_rst, o_op_ready, o_op_done, o_op_prog;
   logic [PC_W-1:0] i_ret_pc = '0, i_pc = '0, o_ret_pc, o_op_addr;
   logic [BSR_W-1:0] i_bsr_d = '0, o_bsr;
   logic [1:0] i_op_mode = '0;
   logic [6:0] i_op_f = '0;
   logic [8:0] i_op_rel = '0;
   logic [OPC_W-1:0] i_alu_opcode = '0;
   logic [DATA_W-1:0] i_alu_operand = '0, o_alu_result, o_wreg, o_status, mem_q;
   logic [5:0] t_op [8] = '{6'h00, 6'h01, 6'h04, 6'h05, 6'h03, 6'h06, 6'h02, 6'h07};
   logic [7:0] t_d [8] = '{8'hA5, 8'h5B, 8'h0F, 8'hFF, 8'h3C, 8'h7F, 8'h01, 8'h00};
   logic [7:0] t_w [8] = '{8'hA5, 8'h00, 8'h0F, 8'hF0, 8'h30, 8'h80, 8'h7F, 8'h00};
   int errors = 0, samples_checked = 0, rst_seen = 0, i;
   always #2 i_clk = ~i_clk;
   always @(posedge i_clk) if (o_soft_rst === 1'b1) rst_seen <= rst_seen + 1;
   csia_core i_csia_core (.*);
   csia_mem_model i_csia_mem_model (.i_clk(i_clk), .i_done(o_op_done), .i_prog(o_op_prog),
      .i_addr(o_op_addr), .o_q(mem_q));
   // ------
   // Tasks
   // ------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_avs_address <= a;
      i_avs_write <= wr;
      i_avs_read <= ~wr;
      i_avs_writedata <= d;
      do begin
         @(posedge i_clk);
      end while (o_avs_waitrequest !== 1'b0);
      q = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      #1;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task stk(input logic c, input logic r, input logic [14:0] pc);
      @(posedge i_clk);
      i_call <= c;
      i_ret <= r;
      i_ret_pc <= pc;
      @(posedge i_clk);
      i_call <= 1'b0;
      i_ret <= 1'b0;
      #1;
   endtask
   task ctx(input logic e, input logic r, input logic w, input logic [5:0] b);
      @(posedge i_clk);
      i_int_entry <= e;
      i_int_return <= r;
      i_bsr_we <= w;
      i_bsr_d <= b;
      @(posedge i_clk);
      i_int_entry <= 1'b0;
      i_int_return <= 1'b0;
      i_bsr_we <= 1'b0;
      #1;
   endtask
   task alu(input logic [5:0] opc, input logic [7:0] d);
      @(posedge i_clk);
      i_alu_valid <= 1'b1;
      i_alu_opcode <= opc;
      i_alu_operand <= d;
      @(posedge i_clk);
      i_alu_valid <= 1'b0;
      #1;
   endtask
   task op(input logic [1:0] m, input logic [8:0] r, input logic [14:0] pc,
      input logic p, input logic [14:0] a, input int lat);
      int n;
      @(posedge i_clk);
      i_op_valid <= 1'b1;
      i_op_mode <= m;
      i_op_f <= 7'h15;
      i_op_rel <= r;
      i_pc <= pc;
      @(posedge i_clk);
      i_op_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_op_done !== 1'b1 && n < 8);
      chk(32'(n), 32'(lat));
      chk(o_op_prog, p);
      chk(o_op_addr, a);
      alu(6'h00, mem_q);
      chk(o_wreg, a[7:0] ^ {p, 7'h00});
   endtask
   // ------
   // Tests
   // ------
   initial begin
      #40000;
      errors++;
      test_done;
   end
   initial begin
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
      for (i = 0; i < 9; i++) rd(8'(i * 4), 32'h0);
      bus(1'b1, 8'h10, 32'hFFFFFFFF);
      bus(1'b1, 8'h14, 32'h00001234);
      bus(1'b1, 8'h18, 32'h00000005);
      bus(1'b1, 8'h40, 32'h00000007);
      rd(8'h10, 32'h0000FFFF);
      rd(8'h14, 32'h00001234);
      rd(8'h18, 32'h0);
      rd(8'h40, 32'h0);
      ctx(1'b0, 1'b0, 1'b1, 6'h2A);
      op(AM_DIRECT, 9'h000, 15'h0000, 1'b0, 15'h1515, 1);
      op(AM_REL, 9'h1FE, 15'h0100, 1'b1, 15'h00FF, 1);
      op(AM_REL, 9'h001, 15'h7FFF, 1'b1, 15'h0001, 1);
      bus(1'b1, 8'h10, 32'h00008123);
      op(AM_IND0, 9'h000, 15'h0000, 1'b1, 15'h0123, 2);
      bus(1'b1, 8'h14, 32'h00002050);
      op(AM_IND1, 9'h000, 15'h0000, 1'b0, 15'h00A0, 1);
      bus(1'b1, 8'h14, 32'h0000204F);
      op(AM_IND1, 9'h000, 15'h0000, 1'b0, 15'h006F, 1);
      bus(1'b1, 8'h10, 32'h00001ABC);
      op(AM_IND0, 9'h000, 15'h0000, 1'b0, 15'h1ABC, 1);
      for (i = 0; i < 8; i++) begin
         alu(t_op[i], t_d[i]);
         chk(o_wreg, t_w[i]);
         chk(o_alu_result, t_w[i]);
         if (i == 1) chk({o_status[STAT_C_BIT], o_status[STAT_Z_BIT]}, 2'b11);
      end
      alu(6'h30, 8'h55);
      alu(6'h3F, 8'h55);
      chk(o_wreg, 8'h00);
      rd(8'h08, 32'h4);
      alu(6'h00, 8'h5A);
      bus(1'b1, 8'h10, 32'h00001111);
      ctx(1'b1, 1'b0, 1'b0, 6'h00);
      ctx(1'b0, 1'b0, 1'b1, 6'h05);
      alu(6'h07, 8'h00);
      bus(1'b1, 8'h10, 32'h00002222);
      ctx(1'b0, 1'b1, 1'b0, 6'h00);
      chk(o_wreg, 8'h5A);
      chk(o_bsr, 6'h2A);
      rd(8'h10, 32'h00001111);
      rd(8'h18, 32'h0);
      i_ce <= 1'b0;
      stk(1'b1, 1'b0, 15'h0003);
      i_ce <= 1'b1;
      rd(8'h18, 32'h0);
      for (i = 0; i < 16; i++) stk(1'b1, 1'b0, 15'(i * 3 + 1));
      rd(8'h18, 32'h10);
      stk(1'b1, 1'b0, 15'h7FFF);
      chk(o_irq, 1'b0);
      rd(8'h04, 32'h1);
      bus(1'b1, 8'h0C, 32'h7);
      chk(o_irq, 1'b1);
      rd(8'h08, 32'h1);
      chk(o_irq, 1'b0);
      for (i = 15; i >= 0; i--) begin
         stk(1'b0, 1'b1, 15'h0000);
         chk(o_ret_pc, 15'(i * 3 + 1));
      end
      @(posedge i_clk);
      i_call <= 1'b1;
      i_ret_pc <= 15'h2AAA;
      @(posedge i_clk);
      i_call <= 1'b0;
      i_ret <= 1'b1;
      @(posedge i_clk);
      i_ret <= 1'b0;
      #1;
      chk(o_ret_pc, 15'h2AAA);
      stk(1'b0, 1'b1, 15'h0000);
      chk(o_ret_pc, 15'h0000);
      chk(32'(rst_seen), 32'h0);
      rd(8'h04, 32'h3);
      bus(1'b1, 8'h04, 32'h3);
      rd(8'h04, 32'h0);
      rd(8'h08, 32'h2);
      bus(1'b1, 8'h00, 32'h1);
      stk(1'b0, 1'b1, 15'h0000);
      repeat (2) @(posedge i_clk);
      #1;
      chk(32'(rst_seen), 32'h1);
      rd(8'h04, 32'h2);
      test_done;
   end
endmodule
`default_nettype wire
